// ==== src/sps_pkg.sv ====
// package of constants and types for the shutdown and power-up sequencer
package sps_pkg;
   // clock rate and timing figures
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned PWRUP_MAX_MS = 100;
   localparam int unsigned SLOW_CLK_MS = 2;
   localparam int unsigned FAST_CLK_MS = 20;
   // default power-up settle time, well inside the 100 ms limit
   localparam int unsigned PWRUP_SETTLE_MS = 25;
   localparam int unsigned PWRUP_SETTLE_CYC = PWRUP_SETTLE_MS * (CLK_HZ / 1000);
   localparam int unsigned PWRUP_MAX_CYC = PWRUP_MAX_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W = 32;
   // pad configuration reset value: high impedance, pull on
   localparam logic PAD_OE_RST = 1'h0;
   localparam logic PAD_PULL_EN_RST = 1'h1;
   // pad indices inside the pad vector
   localparam int unsigned PAD_RX = 0;
   localparam int unsigned PAD_TX = 1;
   localparam int unsigned PAD_RTS = 2;
   localparam int unsigned PAD_CTS = 3;
   localparam int unsigned PAD_ACLK = 4;
   localparam int unsigned PAD_AFS = 5;
   localparam int unsigned PAD_AIN = 6;
   localparam int unsigned PAD_AOUT = 7;
   localparam int unsigned PAD_DBG = 8;
   localparam int unsigned NUM_PADS = 9;
   // pull direction per pad: 1 = pullup, 0 = pulldown
   localparam logic [8:0] PAD_PULL_UP = 9'h10F;
   // power states, gray coded along shutdown -> power up -> active
   typedef enum logic [1:0] {
      SPS_SHUTDOWN = 2'h0,
      SPS_POWERUP = 2'h1,
      SPS_ACTIVE = 2'h3
   } sps_state_e;
endpackage

// ==== src/sps_pad_if.sv ====
// interface carrying one pad's control between sequencer and pad cell
`timescale 1ns/1ps
interface sps_pad_if;
   logic active;
   logic is_output;
   logic pull_up;
   logic out_val;
   logic oe;
   logic pull_en;
   logic pull_dir;
   logic drv;
   modport ctrl (output active, output is_output, output pull_up, output out_val,
      input oe, input pull_en, input pull_dir, input drv);
   modport pad (input active, input is_output, input pull_up, input out_val,
      output oe, output pull_en, output pull_dir, output drv);
endinterface

// ==== src/sps_pad_ctrl.sv ====
// one pad's registered drive and pull control
`timescale 1ns/1ps
module sps_pad_ctrl
   import sps_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   sps_pad_if.pad pif
);
   // high impedance with pull until active; outputs then drive without pull
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pif.oe <= PAD_OE_RST;
         pif.pull_en <= PAD_PULL_EN_RST;
         pif.pull_dir <= 1'h0;
         pif.drv <= 1'h0;
      end else begin
         pif.oe <= pif.active & pif.is_output;
         pif.pull_en <= ~(pif.active & pif.is_output);
         pif.pull_dir <= pif.pull_up;
         pif.drv <= pif.active & pif.is_output & pif.out_val;
      end
   end
endmodule

// ==== src/sps_sequencer.sv ====
// shutdown and power-up sequencer with power-mode pad control
`timescale 1ns/1ps
import sps_pkg::*;
// Overview of operation
// - while power-off request is low, stay in shutdown and hold logic in reset
// - drive request-to-send low when power-up ends, within 100 ms of release; rts follows host_link_rts_busy
// - all pins high impedance with pull during shutdown and power-up
// - low, pulled-down or floating request means shutdown; active needs supplies
// - internal pulldown keeps power-off request in shutdown when undriven
// - active: receive, clear-to-send pulled-up inputs; transmit, rts outputs; audio pulldown
// - shutdown: host link and debug pulled up, audio pulled down, all high impedance; all pads pull down from reset until the first clock edge after it
module sps_sequencer
   import sps_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = PWRUP_SETTLE_CYC
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic power_off_request_n,
   input wire logic main_supply_ok,
   input wire logic io_supply_ok,
   input wire logic fast_clk_ok,
   input wire logic slow_clk_ok,
   input wire logic host_link_tx_data,
   input wire logic host_link_rts_busy,
   input wire logic debug_trace_data,
   output logic [1:0] power_state,
   output logic core_reset_n,
   output logic power_off_request_pull_down,
   output logic [NUM_PADS-1:0] pad_oe,
   output logic [NUM_PADS-1:0] pad_pull_en,
   output logic [NUM_PADS-1:0] pad_pull_up,
   output logic [NUM_PADS-1:0] pad_out
);
   ////////////////////////////////////////////////////////////////////////////
   // state and counter
   sps_state_e state_q;
   sps_state_e state_d;
   logic [CNT_W-1:0] cnt_q;
   logic run_ok;
   logic settled;
   logic [NUM_PADS-1:0] pad_is_out;
   logic [NUM_PADS-1:0] pad_val;

   // a floating or pulled-down request reads low, so only a driven high runs
   assign run_ok = power_off_request_n & main_supply_ok & io_supply_ok;
   // both clocks reported stable and the settle time spent
   assign settled = (cnt_q >= CNT_W'(SETTLE_CYC)) & fast_clk_ok & slow_clk_ok;

   // next-state selection
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SPS_SHUTDOWN: begin
            if (run_ok) begin
               state_d = SPS_POWERUP;
            end
         end
         SPS_POWERUP: begin
            if (!run_ok) begin
               state_d = SPS_SHUTDOWN;
            end else if (settled || cnt_q >= CNT_W'(PWRUP_MAX_CYC - 2)) begin
               state_d = SPS_ACTIVE;
            end
         end
         SPS_ACTIVE: begin
            if (!run_ok) begin
               state_d = SPS_SHUTDOWN;
            end
         end
         default: state_d = SPS_SHUTDOWN;
      endcase
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SPS_SHUTDOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // cycles since release, counted only during power-up
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (state_q == SPS_POWERUP && run_ok) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end else begin
         cnt_q <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_state <= SPS_SHUTDOWN;
         core_reset_n <= 1'h0;
         power_off_request_pull_down <= 1'h1;
      end else begin
         power_state <= state_d;
         core_reset_n <= (state_d == SPS_ACTIVE);
         power_off_request_pull_down <= 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pad configuration per pad
   // outputs in active mode: transmit, rts, debug; rts follows host_link_rts_busy once active
   always_comb begin
      pad_is_out = '0;
      pad_is_out[PAD_TX] = 1'h1;
      pad_is_out[PAD_RTS] = 1'h1;
      pad_is_out[PAD_DBG] = 1'h1;
      pad_val = '0;
      pad_val[PAD_TX] = host_link_tx_data;
      pad_val[PAD_RTS] = host_link_rts_busy;
      pad_val[PAD_DBG] = debug_trace_data;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PADS; gi++) begin : g_pad
         sps_pad_if pif ();
         // pads leave high impedance only once active
         assign pif.active = (state_d == SPS_ACTIVE);
         assign pif.is_output = pad_is_out[gi];
         assign pif.pull_up = PAD_PULL_UP[gi];
         assign pif.out_val = pad_val[gi];
         sps_pad_ctrl u_pad (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pif(pif)
         );
         assign pad_oe[gi] = pif.oe;
         assign pad_pull_en[gi] = pif.pull_en;
         assign pad_pull_up[gi] = pif.pull_dir;
         assign pad_out[gi] = pif.drv;
      end
   endgenerate
endmodule

// ==== dv/sps_sequencer_sva.sv ====
// port assertions for the sequencer
`timescale 1ns/1ps
module sps_sequencer_sva
   import sps_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic power_off_request_n,
   input wire logic main_supply_ok,
   input wire logic io_supply_ok,
   input wire logic host_link_rts_busy,
   input wire logic [1:0] power_state,
   input wire logic core_reset_n,
   input wire logic power_off_request_pull_down,
   input wire logic [NUM_PADS-1:0] pad_oe,
   input wire logic [NUM_PADS-1:0] pad_pull_en,
   input wire logic [NUM_PADS-1:0] pad_pull_up,
   input wire logic [NUM_PADS-1:0] pad_out
);
   wire logic run_ok = power_off_request_n & main_supply_ok & io_supply_ok;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // state and pad relations
   property p_off; !run_ok |=> power_state == SPS_SHUTDOWN && !core_reset_n; endproperty
   a_off: assert property (p_off) else $error("no shutdown");
   property p_hiz; power_state != SPS_ACTIVE |-> pad_oe == 9'h0 && &pad_pull_en; endproperty
   a_hiz: assert property (p_hiz) else $error("pad driven");
   property p_pull; 1 ##1 power_state == SPS_SHUTDOWN |-> pad_pull_up == PAD_PULL_UP; endproperty
   a_pull: assert property (p_pull) else $error("pull dir");
   property p_pd; 1 |=> power_off_request_pull_down; endproperty
   a_pd: assert property (p_pd) else $error("no pulldown");
   property p_core; core_reset_n == (power_state == SPS_ACTIVE); endproperty
   a_core: assert property (p_core) else $error("core reset");
   property p_act; power_state == SPS_ACTIVE |-> pad_oe == 9'h106 && pad_pull_en == 9'h0F9; endproperty
   a_act: assert property (p_act) else $error("active pads");
   property p_rts; power_state == SPS_ACTIVE |-> pad_out[PAD_RTS] == $past(host_link_rts_busy);
   endproperty
   a_rts: assert property (p_rts) else $error("rts value");
   property p_wake; power_state == SPS_SHUTDOWN && run_ok |=> power_state == SPS_POWERUP;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
endmodule
bind sps_sequencer sps_sequencer_sva i_sps_sequencer_sva (.*);

// ==== dv/sps_host_model.sv ====
// host side: request pin, supplies, clocks and power-up timeout
`timescale 1ns/1ps
module sps_host_model #(
   parameter int SLOW = 3,
   parameter int FAST = 10,
   parameter int TMO = 200
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [1:0] sup,
   input wire logic rts_low,
   output logic power_off_request_n,
   output logic main_supply_ok,
   output logic io_supply_ok,
   output logic fast_clk_ok,
   output logic slow_clk_ok,
   output logic pu_fail
);
   int cnt_q;
   // release only with both supplies up, hold low after own reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_off_request_n <= 1'h0;
         cnt_q <= 0;
         pu_fail <= 1'h0;
      end else begin
         power_off_request_n <= run & (power_off_request_n | &sup);
         cnt_q <= power_off_request_n ? cnt_q + 1 : 0;
         pu_fail <= power_off_request_n & !rts_low & cnt_q >= TMO;
      end
   end
   // supplies and clocks seen by the device
   assign {io_supply_ok, main_supply_ok} = sup;
   assign fast_clk_ok = power_off_request_n & cnt_q >= FAST;
   assign slow_clk_ok = power_off_request_n & cnt_q >= SLOW;
endmodule

// ==== dv/test_sps_sequencer.sv ====
// self-checking bench for the sequencer
`timescale 1ns/1ps
module test_sps_sequencer
   import sps_pkg::*;
;
   localparam int SETTLE = 20;
   logic sys_clk = 1'h0, rst_n = 1'h0, run = 1'h0, tx = 1'h0, busy = 1'h0, dbg = 1'h0;
   logic [1:0] sup = 2'h3;
   logic req_n, m_ok, io_ok, f_ok, s_ok, pu_fail, core_reset_n, pd;
   logic [1:0] power_state;
   logic [NUM_PADS-1:0] pad_oe, pad_pull_en, pad_pull_up, pad_out;
   int bad_count = 0, checks_done = 0, n;
   // row: run, io supply, main supply, active expected
   logic [3:0] rows [8] = '{4'h6, 4'hF, 4'hA, 4'hF, 4'hC, 4'h6, 4'h8, 4'hF};
   sps_host_model i_sps_host_model (.sys_clk(sys_clk), .rst_n(rst_n), .run(run), .sup(sup),
      .rts_low(pad_oe[PAD_RTS] & !pad_out[PAD_RTS]), .power_off_request_n(req_n),
      .main_supply_ok(m_ok), .io_supply_ok(io_ok), .fast_clk_ok(f_ok), .slow_clk_ok(s_ok),
      .pu_fail(pu_fail));
   sps_sequencer #(.SETTLE_CYC(SETTLE)) i_sps_sequencer (.sys_clk(sys_clk), .rst_n(rst_n),
      .power_off_request_n(req_n), .main_supply_ok(m_ok), .io_supply_ok(io_ok),
      .fast_clk_ok(f_ok), .slow_clk_ok(s_ok), .host_link_tx_data(tx),
      .host_link_rts_busy(busy), .debug_trace_data(dbg), .power_state(power_state),
      .core_reset_n(core_reset_n), .power_off_request_pull_down(pd), .pad_oe(pad_oe),
      .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up), .pad_out(pad_out));
   always #12.5 sys_clk = ~sys_clk;
   task automatic chk(string nm, logic [8:0] seen, logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      if (bad_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // table rows, then pass-through, wake timing and mid-run reset
   initial begin
      repeat (2) @(posedge sys_clk);
      #1 rst_n = 1'h1;
      foreach (rows[i]) begin
         {run, sup} = rows[i][3:1];
         repeat (60) @(posedge sys_clk);
         #1 chk("state", 9'(power_state), rows[i][0] ? 9'h3 : 9'h0);
         chk("oe", pad_oe, rows[i][0] ? 9'h106 : 9'h000);
         chk("pull", pad_pull_en, rows[i][0] ? 9'h0F9 : 9'h1FF);
      end
      {tx, busy, dbg} = 3'h5;
      repeat (2) @(posedge sys_clk);
      #1 chk("out", pad_out & 9'h106, 9'h102);
      busy = 1'h1;
      repeat (2) @(posedge sys_clk);
      #1 chk("rts_busy", pad_out & 9'h106, 9'h106);
      busy = 1'h0;
      run = 1'h0;
      repeat (10) @(posedge sys_clk);
      #1 run = 1'h1;
      n = 0;
      while (!(pad_oe[PAD_RTS] === 1'h1 && pad_out[PAD_RTS] === 1'h0) && n < 400) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk("rts_time", 9'(n > SETTLE && n <= SETTLE + 20), 9'h1);
      chk("fail", 9'(pu_fail), 9'h0);
      chk("pd", 9'(pd), 9'h1);
      rst_n = 1'h0;
      #1 chk("rst", {core_reset_n, power_state, pad_oe[5:0]}, 9'h0);
      chk("rst_pull", pad_pull_up, 9'h0);
      // hold the mid-run reset across two clock edges
      repeat (2) @(posedge sys_clk);
      #1 chk("rst_hold", {core_reset_n, power_state, pad_oe[5:0]}, 9'h0);
      rst_n = 1'h1;
      repeat (2) @(posedge sys_clk);
      #1 chk("pull_up", pad_pull_up, PAD_PULL_UP);
      chk("state_rst", 9'(power_state), 9'h1);
      test_done();
   end
   // watchdog
   initial begin
      repeat (5000) @(posedge sys_clk);
      bad_count++;
      test_done();
   end
endmodule
